// ---- hdl/trace_seq_pkg.sv ----
// Constants, field positions and state codes for the trace trigger sequencer.
// Assumes one clock domain and configuration driven by a host-side controller.
package trace_seq_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int STAT_W = 3;
    localparam int PROBE_W = 4;
    localparam int IRQ_W  = 9;             // NMI plus eight request lines.
    localparam int CHANS  = 8;             // Channels 1 to 8 per set.
    localparam int SETS   = 3;             // Sets A, B and C.
    localparam int SEQ_SETS = 2;           // Only A and B can run sequences.
    localparam int NCH    = CHANS * SETS;
    // Channel roles.
    localparam logic [1:0] ROLE_OFF   = 2'h0;
    localparam logic [1:0] ROLE_RANGE = 2'h1;
    localparam logic [1:0] ROLE_STOP  = 2'h2;
    localparam logic [1:0] ROLE_RESET = 2'h3;
    localparam logic [1:0] ROLE_RST   = ROLE_OFF;
    // Sub-condition enable bit positions.
    localparam int EN_W     = 6;
    localparam int EN_ADDR  = 0;
    localparam int EN_DATA  = 1;
    localparam int EN_STAT  = 2;
    localparam int EN_RW    = 3;
    localparam int EN_IRQ   = 4;
    localparam int EN_PROBE = 5;
    localparam logic [EN_W-1:0] EN_RST        = 6'h00;
    localparam logic [EN_W-1:0] SET_C_EN_MASK = 6'h09; // Address and direction only.
    // Sequence layout: channels 1..7 are ordered steps, channel 8 the reset point.
    localparam logic [2:0] RESET_CHAN = 3'h7;
    localparam logic [2:0] STEP_RST   = 3'h0;
    localparam logic [1:0] SET_LIMIT  = 2'h3;
    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'b01,
        ST_HALTED  = 2'b10
    } acq_state_e;
endpackage

// ---- hdl/trace_trigger_sequencer.sv ----
// Trace qualification, sequential stop and trigger output for an emulator probe.
// Assumes bus signals are sampled on clk and bus_valid marks one target bus cycle.
// Functional notes
// - Sequence of up to seven steps plus reset point.
// - Stop only after all steps in order.
// - Reset point returns sequence to first step.
// - Sequential mode exists only for sets A, B.
// - Entering sequential mode clears that set's conditions.
// - Optional halt on trace buffer overflow.
// - Range mode stores only matching cycles.
// - Qualifier is AND of enabled sub-conditions.
// - Address matches programmed value.
// - Data matches programmed value.
// - Bus status matches programmed access type.
// - Direction matches programmed read/write.
// - NMI and request line levels match pattern.
// - Probe input levels match pattern.
// - Sets A, B full; set C address, direction.
// - Programmed break channels lock out the set.
// - Stop condition enters trace-halt, target continues.
// - Set B match pulses trigger output low.
`timescale 1ns/1ps
module trace_trigger_sequencer (
    input  wire logic                              clk,
    input  wire logic                              rst_n,
    input  wire logic                              bus_valid,
    input  wire logic [trace_seq_pkg::ADDR_W-1:0]  bus_addr,
    input  wire logic [trace_seq_pkg::DATA_W-1:0]  bus_data,
    input  wire logic [trace_seq_pkg::STAT_W-1:0]  bus_status,
    input  wire logic                              bus_read,
    input  wire logic                              nmi_level,
    input  wire logic [7:0]                        interrupt_request_lines,
    input  wire logic [trace_seq_pkg::PROBE_W-1:0] external_probe_inputs,
    input  wire logic                              emu_running,
    input  wire logic                              run_start,
    input  wire logic                              cfg_we,
    input  wire logic [1:0]                        cfg_set,
    input  wire logic [2:0]                        cfg_chan,
    input  wire logic [1:0]                        cfg_role,
    input  wire logic [trace_seq_pkg::EN_W-1:0]    cfg_enable,
    input  wire logic [trace_seq_pkg::ADDR_W-1:0]  cfg_addr,
    input  wire logic [trace_seq_pkg::DATA_W-1:0]  cfg_data,
    input  wire logic [trace_seq_pkg::STAT_W-1:0]  cfg_status,
    input  wire logic                              cfg_read,
    input  wire logic [trace_seq_pkg::IRQ_W-1:0]   cfg_irq,
    input  wire logic [trace_seq_pkg::PROBE_W-1:0] cfg_probe,
    input  wire logic [trace_seq_pkg::SETS-1:0]    break_programmed,
    input  wire logic                              seq_mode_a,
    input  wire logic                              seq_mode_b,
    input  wire logic [2:0]                        seq_len_a,
    input  wire logic [2:0]                        seq_len_b,
    input  wire logic                              overflow_stop_en,
    input  wire logic                              buffer_overflow,
    output logic                                   trace_store,
    output logic [trace_seq_pkg::ADDR_W-1:0]       trace_addr,
    output logic [trace_seq_pkg::DATA_W-1:0]       trace_data,
    output logic                                   trace_halt,
    output logic [2:0]                             seq_step_a,
    output logic [2:0]                             seq_step_b,
    output logic                                   trigger_out_n
);
    import trace_seq_pkg::*;

    // Per-channel programmed conditions; values need no reset since role gates them.
    logic [1:0]        role_reg [NCH];
    logic [EN_W-1:0]   en_reg   [NCH];
    logic [ADDR_W-1:0] addr_reg [NCH];
    logic [DATA_W-1:0] data_reg [NCH];
    logic [STAT_W-1:0] stat_reg [NCH];
    logic              rd_reg   [NCH];
    logic [IRQ_W-1:0]  irq_reg  [NCH];
    logic [PROBE_W-1:0] probe_reg [NCH];
    logic [2:0]        step_reg [SEQ_SETS];
    logic [2:0]        len_prev_reg [SEQ_SETS];
    logic [SEQ_SETS-1:0] mode_prev_reg;
    acq_state_e        state_reg;
    acq_state_e        state_next;
    logic              store_reg;
    logic [ADDR_W-1:0] taddr_reg;
    logic [DATA_W-1:0] tdata_reg;
    logic              trig_n_reg;

    wire              cyc = bus_valid & emu_running;
    wire [4:0]        cfg_idx = {cfg_set, cfg_chan};
    wire              cfg_ok = cfg_we & (cfg_set < SET_LIMIT);
    wire [IRQ_W-1:0]  irq_now = {nmi_level, interrupt_request_lines};
    wire [SEQ_SETS-1:0] seq_mode = {seq_mode_b, seq_mode_a};
    wire [2:0]        seq_len [SEQ_SETS];
    wire [NCH-1:0]    chan_hit;
    wire [NCH-1:0]    range_hit;
    wire [NCH-1:0]    range_on;
    wire [NCH-1:0]    stop_hit;
    wire [NCH-1:0]    wr_hit;
    wire [SETS-1:0]   clear_set;
    wire [SEQ_SETS-1:0] seq_stop;
    wire [SEQ_SETS-1:0] hit_exp;
    wire [SEQ_SETS-1:0] hit_rst;
    wire [SEQ_SETS-1:0] reprog;
    wire [SETS-1:0]   plain_stop;

    assign seq_len[0] = seq_len_a;
    assign seq_len[1] = seq_len_b;
    // A set is wiped on the cycle its sequential mode switches on.
    assign clear_set = {1'b0, seq_mode & ~mode_prev_reg};

    // One comparator bank per channel; set C ignores all but address and direction.
    for (genvar i = 0; i < NCH; i++) begin : g_chan
        localparam int S = i / CHANS;
        wire [EN_W-1:0] en = (S == 2) ? (en_reg[i] & SET_C_EN_MASK) : en_reg[i];
        wire m_addr = !en[EN_ADDR]  | (bus_addr == addr_reg[i]);
        wire m_data = !en[EN_DATA]  | (bus_data == data_reg[i]);
        wire m_stat = !en[EN_STAT]  | (bus_status == stat_reg[i]);
        wire m_rw   = !en[EN_RW]    | (bus_read == rd_reg[i]);
        wire m_irq  = !en[EN_IRQ]   | (irq_now == irq_reg[i]);
        wire m_probe = !en[EN_PROBE] | (external_probe_inputs == probe_reg[i]);
        wire live   = (role_reg[i] != ROLE_OFF) & !break_programmed[S];
        assign chan_hit[i]  = cyc & live & m_addr & m_data & m_stat & m_rw & m_irq & m_probe;
        assign range_on[i]  = live & (role_reg[i] == ROLE_RANGE);
        assign range_hit[i] = chan_hit[i] & (role_reg[i] == ROLE_RANGE);
        assign stop_hit[i]  = chan_hit[i] & (role_reg[i] == ROLE_STOP);
        // Writes into a set whose break channels are in use are dropped.
        assign wr_hit[i] = cfg_ok & (cfg_idx == 5'(i)) & !break_programmed[S];
    end

    // Roles and enables reset; a mode switch clears them ahead of a same-cycle write.
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (!rst_n || clear_set[i / CHANS]) begin
                role_reg[i] <= ROLE_RST;
                en_reg[i]   <= EN_RST;
            end else if (wr_hit[i]) begin
                role_reg[i] <= cfg_role;
                en_reg[i]   <= cfg_enable;
            end
        end
    end

    // Comparison values are only captured; they have no effect while the role is off.
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (wr_hit[i]) begin
                addr_reg[i] <= cfg_addr;
                data_reg[i] <= cfg_data;
                stat_reg[i] <= cfg_status;
                rd_reg[i]   <= cfg_read;
                irq_reg[i]  <= cfg_irq;
                probe_reg[i] <= cfg_probe;
            end
        end
    end

    // Sequence progress for sets A and B. Only the expected step can advance it.
    for (genvar s = 0; s < SEQ_SETS; s++) begin : g_seq
        wire [CHANS-1:0] steps = stop_hit[s*CHANS +: CHANS];
        wire rst_pt = chan_hit[s*CHANS + CHANS - 1]
                      & (role_reg[s*CHANS + CHANS - 1] == ROLE_RESET);
        wire [2:0] step_inc = step_reg[s] + 3'h1;
        wire [2:0] step_next;
        assign hit_exp[s]  = seq_mode[s] & (step_reg[s] < seq_len[s])
                             & steps[step_reg[s]];
        assign hit_rst[s]  = seq_mode[s] & rst_pt;
        assign seq_stop[s] = hit_exp[s] & !hit_rst[s] & (step_inc == seq_len[s]);
        assign reprog[s]   = (seq_mode[s] != mode_prev_reg[s])
                             | (seq_len[s] != len_prev_reg[s])
                             | (|wr_hit[s*CHANS +: CHANS]);
        assign step_next = (run_start | reprog[s] | hit_rst[s]) ? STEP_RST :
                           hit_exp[s] ? step_inc : step_reg[s];
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                step_reg[s]     <= STEP_RST;
                len_prev_reg[s] <= STEP_RST;
            end else begin
                step_reg[s]     <= step_next;
                len_prev_reg[s] <= seq_len[s];
            end
        end

        sequence final_step_s;
            hit_exp[s] && !hit_rst[s] && step_inc == seq_len[s] && !run_start;
        endsequence
        sequence halted_s;
            state_reg == ST_HALTED;
        endsequence
        seq_final_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
            final_step_s |=> halted_s)
            else $error("Final sequence step did not halt acquisition.");
        seq_reset_pt_a: assert property (@(posedge clk) disable iff (!rst_n)
            hit_rst[s] |=> step_reg[s] == STEP_RST)
            else $error("Reset point did not clear sequence progress.");
        seq_order_a: assert property (@(posedge clk) disable iff (!rst_n)
            step_reg[s] != $past(step_reg[s]) |->
                (step_reg[s] == STEP_RST || step_reg[s] == $past(step_reg[s]) + 3'h1))
            else $error("Sequence progress jumped out of order.");
        seq_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
            run_start |=> step_reg[s] == STEP_RST)
            else $error("New run did not restart the sequence.");
    end

    // Non-sequential stop channels act alone; set C never runs a sequence.
    for (genvar s = 0; s < SETS; s++) begin : g_stop
        wire seq_on = (s < SEQ_SETS) ? seq_mode[s % SEQ_SETS] : 1'b0;
        assign plain_stop[s] = !seq_on & (|stop_hit[s*CHANS +: CHANS]);
    end

    wire ovf_stop = overflow_stop_en & buffer_overflow;
    wire stop_now = (|plain_stop) | (|seq_stop) | ovf_stop;
    // With no range channel programmed every cycle is stored.
    wire range_ok = !(|range_on) | (|range_hit);
    wire acquiring = (state_reg == ST_ACQUIRE);
    wire b_hit = |chan_hit[CHANS +: CHANS];

    // Halt only stops acquisition; the target keeps running until run_start rearms.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_ACQUIRE: if (stop_now) state_next = ST_HALTED;
            ST_HALTED:  if (run_start) state_next = ST_ACQUIRE;
        endcase
        if (run_start) state_next = ST_ACQUIRE;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg     <= ST_ACQUIRE;
            mode_prev_reg <= '0;
            store_reg     <= 1'b0;
            taddr_reg     <= '0;
            tdata_reg     <= '0;
            trig_n_reg    <= 1'b1;
        end else begin
            state_reg     <= state_next;
            mode_prev_reg <= seq_mode;
            store_reg     <= cyc & acquiring & range_ok;
            taddr_reg     <= bus_addr;
            tdata_reg     <= bus_data;
            trig_n_reg    <= !b_hit;
        end
    end

    assign trace_store   = store_reg;
    assign trace_addr    = taddr_reg;
    assign trace_data    = tdata_reg;
    assign trace_halt    = (state_reg == ST_HALTED);
    assign seq_step_a    = step_reg[0];
    assign seq_step_b    = step_reg[1];
    assign trigger_out_n = trig_n_reg;

    halt_on_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (|plain_stop) && !run_start |=> trace_halt)
        else $error("Stop channel hit did not halt acquisition.");
    overflow_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
        !overflow_stop_en && !(|stop_hit) && acquiring && !(|seq_stop) |=> !trace_halt)
        else $error("Acquisition halted without a stop cause.");
    range_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        trace_store |-> $past(acquiring) && $past(cyc) && $past(range_ok))
        else $error("Cycle stored outside range qualification.");
    // Role of the addressed channel; the check below follows the same channel a cycle later,
    // so a host that moves on to another channel at once does not fool it.
    wire [1:0] cfg_role_seen = role_reg[cfg_idx % NCH];
    lockout_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_we && break_programmed[cfg_set % SETS] && !(|clear_set)
            |=> role_reg[$past(cfg_idx) % NCH] == $past(cfg_role_seen))
        else $error("Locked-out set accepted a trace write.");
    clear_on_seq_a: assert property (@(posedge clk) disable iff (!rst_n)
        clear_set[0] |=> role_reg[0] == ROLE_OFF && role_reg[CHANS-1] == ROLE_OFF)
        else $error("Entering sequential mode left conditions set.");
    trigger_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        b_hit ##1 !b_hit |-> !trigger_out_n ##1 trigger_out_n)
        else $error("Set B match did not give a one-cycle low trigger.");
endmodule // trace_trigger_sequencer

// ---- bench/target_bus_model.sv ----
// Behavioural model of the target processor bus and the external probe and interrupt pins.
// Assumes the bench calls cycle() from its own process; all pins change at falling edges.
`timescale 1ns/1ps
module target_bus_model
    import trace_seq_pkg::*;
(
    input  wire logic              clk,
    output logic                   bus_valid,
    output logic [ADDR_W-1:0]      bus_addr,
    output logic [DATA_W-1:0]      bus_data,
    output logic [STAT_W-1:0]      bus_status,
    output logic                   bus_read,
    output logic                   nmi_level,
    output logic [7:0]             interrupt_request_lines,
    output logic [PROBE_W-1:0]     external_probe_inputs
);
    // Idle bus shows the inverse of the last cycle so stale values never look valid.
    initial begin
        {bus_valid, bus_addr, bus_data, bus_status, bus_read} = '0;
        {nmi_level, interrupt_request_lines, external_probe_inputs} = '0;
    end

    // One target bus cycle lasting exactly one clock.
    task automatic cycle(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                         input logic [STAT_W-1:0] s, input logic r,
                         input logic [IRQ_W-1:0] q, input logic [PROBE_W-1:0] p);
        @(negedge clk);
        bus_valid = 1'b1;
        {bus_addr, bus_data, bus_status, bus_read} = {a, d, s, r};
        {nmi_level, interrupt_request_lines, external_probe_inputs} = {q, p};
        @(negedge clk);
        bus_valid = 1'b0;
        {bus_addr, bus_data, bus_status, bus_read} = ~{a, d, s, r};
    endtask
endmodule // target_bus_model

// ---- bench/trace_trigger_sequencer_tb_top.sv ----
// Self-checking bench for the trace trigger sequencer.
// Assumes the target bus model file is compiled first; inputs change at falling edges.
`timescale 1ns/1ps
module trace_trigger_sequencer_tb_top;
    import trace_seq_pkg::*;
    localparam logic [ADDR_W-1:0] BA = 24'h123456;
    localparam logic [DATA_W-1:0] BD = 16'hbeef;
    localparam logic [STAT_W-1:0] BS = 3'h5;
    localparam logic [IRQ_W-1:0]  BI = 9'h1a5;
    localparam logic [PROBE_W-1:0] BP = 4'h9;
    logic clk = 1'b0, rst_n = 1'b0, run_start = 1'b0, cfg_we = 1'b0, emu_running = 1'b1;
    logic bus_valid, bus_read, nmi_level, cfg_read = 1'b1;
    logic [ADDR_W-1:0] bus_addr, trace_addr, cfg_addr = '0;
    logic [DATA_W-1:0] bus_data, trace_data;
    logic [STAT_W-1:0] bus_status;
    logic [7:0]        interrupt_request_lines;
    logic [PROBE_W-1:0] external_probe_inputs;
    logic [1:0] cfg_set = 2'h0, cfg_role = 2'h0;
    logic [2:0] cfg_chan = 3'h0, seq_len_a = 3'h2, seq_len_b = 3'h7, seq_step_a, seq_step_b;
    logic [EN_W-1:0] cfg_enable = '0;
    logic [SETS-1:0] break_programmed = '0;
    logic seq_mode_a = 1'b0, seq_mode_b = 1'b0, ovf_en = 1'b0, ovf = 1'b0;
    logic trace_store, trace_halt, trigger_out_n;
    int error_cnt = 0, samples_checked = 0;

    always #12.5 clk = ~clk;

    target_bus_model bus_u (.clk(clk), .bus_valid(bus_valid), .bus_addr(bus_addr),
        .bus_data(bus_data), .bus_status(bus_status), .bus_read(bus_read),
        .nmi_level(nmi_level), .interrupt_request_lines(interrupt_request_lines),
        .external_probe_inputs(external_probe_inputs));

    trace_trigger_sequencer dut_u (.clk(clk), .rst_n(rst_n), .bus_valid(bus_valid),
        .bus_addr(bus_addr), .bus_data(bus_data), .bus_status(bus_status),
        .bus_read(bus_read), .nmi_level(nmi_level),
        .interrupt_request_lines(interrupt_request_lines),
        .external_probe_inputs(external_probe_inputs), .emu_running(emu_running),
        .run_start(run_start), .cfg_we(cfg_we), .cfg_set(cfg_set), .cfg_chan(cfg_chan),
        .cfg_role(cfg_role), .cfg_enable(cfg_enable), .cfg_addr(cfg_addr), .cfg_data(BD),
        .cfg_status(BS), .cfg_read(cfg_read), .cfg_irq(BI), .cfg_probe(BP),
        .break_programmed(break_programmed), .seq_mode_a(seq_mode_a),
        .seq_mode_b(seq_mode_b), .seq_len_a(seq_len_a), .seq_len_b(seq_len_b),
        .overflow_stop_en(ovf_en), .buffer_overflow(ovf), .trace_store(trace_store),
        .trace_addr(trace_addr), .trace_data(trace_data), .trace_halt(trace_halt),
        .seq_step_a(seq_step_a), .seq_step_b(seq_step_b), .trigger_out_n(trigger_out_n));

    // Compare four-state values so an unknown never passes.
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One channel write; every field goes in the same clock.
    task automatic wr(input logic [1:0] s, input logic [2:0] c, input logic [1:0] r,
                      input logic [EN_W-1:0] e, input logic [ADDR_W-1:0] a);
        @(negedge clk);
        {cfg_we, cfg_set, cfg_chan, cfg_role, cfg_enable, cfg_addr} = {1'b1, s, c, r, e, a};
        @(negedge clk);
        cfg_we = 1'b0;
    endtask

    // Bus cycle built from the base values with field k inverted (k < 0 keeps all).
    task automatic bus(input int k, input logic [ADDR_W-1:0] a);
        bus_u.cycle(k == 0 ? ~a : a, k == 1 ? ~BD : BD, k == 2 ? ~BS : BS,
                    k == 3 ? 1'b0 : 1'b1, k == 4 ? ~BI : BI, k == 5 ? ~BP : BP);
    endtask

    task automatic pulse_run();
        @(negedge clk);
        run_start = 1'b1;
        @(negedge clk);
        run_start = 1'b0;
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Watchdog sized well above the roughly 120 clocks the tests need.
    initial begin
        #(25 * 5000);
        error_cnt++;
        test_done();
    end

    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        chk("halt after reset", 0, trace_halt);
        chk("trigger after reset", 1, trigger_out_n);
        // Each sub-condition alone: base cycle matches, perturbed field does not.
        for (int k = 0; k < EN_W; k++) begin
            wr(2'h1, 3'h0, ROLE_RANGE, EN_W'(1) << k, BA);
            bus(-1, BA);
            chk("store on match", 1, trace_store);
            chk("trigger on set B match", 0, trigger_out_n);
            chk("trace addr", 32'(BA), 32'(trace_addr));
            bus(k, BA);
            chk("store on mismatch", 0, trace_store);
            chk("no trigger on mismatch", 1, trigger_out_n);
        end
        // A matching cycle while the user program is stopped must be ignored.
        emu_running = 1'b0;
        bus(-1, BA);
        chk("no store when stopped", 0, trace_store);
        chk("no trigger when stopped", 1, trigger_out_n);
        emu_running = 1'b1;
        // All enabled together: a probe mismatch alone blocks storing.
        wr(2'h1, 3'h0, ROLE_RANGE, 6'h3f, BA);
        bus(5, BA);
        chk("and of enables", 0, trace_store);
        wr(2'h1, 3'h0, ROLE_OFF, 6'h00, BA);
        // Set C only honours address and direction, so a data mismatch is ignored.
        wr(2'h2, 3'h0, ROLE_RANGE, 6'h3f, BA);
        bus(1, BA);
        chk("set c masks data", 1, trace_store);
        chk("trace data", {16'h0, ~BD}, 32'(trace_data));
        bus(3, BA);
        chk("set c checks direction", 0, trace_store);
        // A stop programmed before sequential mode must be wiped by the mode switch.
        wr(2'h0, 3'h0, ROLE_STOP, 6'h01, 24'h1);
        @(negedge clk) seq_mode_a = 1'b1;
        bus(-1, 24'h1);
        chk("cleared on mode entry", 0, seq_step_a);
        chk("no halt after clear", 0, trace_halt);
        wr(2'h0, 3'h0, ROLE_STOP, 6'h01, 24'h1);
        wr(2'h0, 3'h1, ROLE_STOP, 6'h01, 24'h2);
        wr(2'h0, 3'h7, ROLE_RESET, 6'h01, 24'h3);
        bus(-1, 24'h2);
        chk("out of order step", 0, seq_step_a);
        bus(-1, 24'h1);
        chk("first step", 1, seq_step_a);
        bus(-1, 24'h3);
        chk("reset point", 0, seq_step_a);
        bus(-1, 24'h1);
        bus(-1, 24'h2);
        chk("halt after sequence", 1, trace_halt);
        bus(-1, BA);
        chk("no store while halted", 0, trace_store);
        pulse_run();
        chk("run clears halt", 0, trace_halt);
        chk("run clears step", 0, seq_step_a);
        // Longest sequence: seven ordered steps in set B.
        @(negedge clk) seq_mode_b = 1'b1;
        for (int i = 0; i < 7; i++) wr(2'h1, 3'(i), ROLE_STOP, 6'h01, 24'(8'h40 + i));
        for (int i = 0; i < 7; i++) begin
            chk("no early halt", 0, trace_halt);
            bus(-1, 24'(8'h40 + i));
            if (i < 6) chk("seven step count", i + 1, seq_step_b);
        end
        chk("halt after seven", 1, trace_halt);
        // A set with a break programmed refuses writes and never matches.
        break_programmed = 3'b010;
        wr(2'h1, 3'h7, ROLE_RANGE, 6'h01, 24'h77);
        pulse_run();
        bus(-1, 24'h77);
        chk("locked set silent", 1, trigger_out_n);
        // Overflow halts only when the option is on.
        ovf = 1'b1;
        bus(-1, BA);
        chk("overflow ignored", 0, trace_halt);
        ovf_en = 1'b1;
        bus(-1, BA);
        chk("overflow halts", 1, trace_halt);
        test_done();
    end
endmodule // trace_trigger_sequencer_tb_top
